/* cc_sink_model.sv */
// Behavioural sink for the completion stream, standing in for the core.
// Assumes one clock; captures the descriptor and counts payload words.
`timescale 1ns/1ps
`default_nettype none
module cc_sink_model #(
  parameter logic [12:0] CAPT_ID = 13'h0A5
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [31:0] cc_tdata,
  input wire logic cc_tvalid,
  input wire logic cc_tlast,
  input wire logic slow,
  input wire logic rc,
  output logic cc_tready,
  output logic [95:0] desc,
  output logic [12:0] cid,
  output logic poisoned,
  output logic [7:0] pkts,
  output logic [7:0] pays,
  output logic [31:0] pay_last
);
  logic [1:0] beat_q;
  logic stall_q;
  // Stalls every other cycle when slow, so the framer must hold its beat
  assign cc_tready = ~(slow & stall_q);
  assign poisoned = desc[46];
  // A root port always takes the client ids; the override counts for an endpoint
  assign cid = (rc | desc[88]) ? desc[87:75] : CAPT_ID;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      stall_q <= 1'b0;
      beat_q <= 2'h0;
      pkts <= 8'h0;
      pays <= 8'h0;
      desc <= 96'h0;
      pay_last <= 32'h0;
    end
    else
    begin
      stall_q <= ~stall_q;
      if (cc_tvalid & cc_tready)
      begin
        // Descriptor fills the first three beats, the rest is payload
        if (beat_q != 2'h3)
          desc[32*beat_q +: 32] <= cc_tdata;
        else
        begin
          pays <= pays + 8'h1;
          pay_last <= cc_tdata;
        end
        if (beat_q != 2'h3)
          beat_q <= beat_q + 2'h1;
        if (cc_tlast)
        begin
          beat_q <= 2'h0;
          pkts <= pkts + 8'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* completion_descriptor_fields_bench.sv */
// Bench for cpl_framer: programs completions over Avalon-MM, judges the stream.
// Assumes cc_sink_model stands in for the core's completion sink.
`timescale 1ns/1ps
`default_nettype none
`include "cpl_regs.svh"
module completion_descriptor_fields_bench;
  import cpl_types_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] cc_tdata;
  logic cc_tvalid;
  logic cc_tlast;
  logic cc_tready;
  logic slow = 1'b0;
  logic rc = 1'b0;
  logic [95:0] desc;
  logic [12:0] cid;
  logic poisoned;
  logic [7:0] pkts;
  logic [7:0] pays;
  logic [7:0] p0;
  logic [7:0] q0;
  logic [31:0] pay_last;
  logic [31:0] rd;
  logic [31:0] stat;
  int errors = 0;
  int total_checks = 0;
  always #5 clk_sys = ~clk_sys;
  cpl_framer dut (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cc_tdata(cc_tdata), .cc_tvalid(cc_tvalid),
    .cc_tlast(cc_tlast), .cc_tready(cc_tready));
  cc_sink_model model (.clk_sys(clk_sys), .reset(reset), .cc_tdata(cc_tdata), .cc_tvalid(cc_tvalid),
    .cc_tlast(cc_tlast), .slow(slow), .rc(rc), .cc_tready(cc_tready), .desc(desc), .cid(cid),
    .poisoned(poisoned), .pkts(pkts), .pays(pays), .pay_last(pay_last));
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic send(input logic [3:0] cfg, input logic [31:0] a, input logic [31:0] b,
    input logic [31:0] c, input int npay);
    p0 = pkts;
    q0 = pays;
    bus(1'b1, `REG_CPL_A, a);
    bus(1'b1, `REG_CPL_B, b);
    bus(1'b1, `REG_CPL_C, c);
    for (int n = 0; n < npay; n++)
      bus(1'b1, `REG_PAYLOAD, 32'hC0DE_0000 + n);
    // Settings first: the GO write builds from the stored ones
    bus(1'b1, `REG_CTRL, {28'h0, cfg});
    bus(1'b1, `REG_CTRL, {28'h0, cfg | 4'h1});
    bus(1'b0, `REG_STAT, 32'h0);
    while (rd[`STAT_BUSY] !== 1'b0)
      bus(1'b0, `REG_STAT, 32'h0);
    stat = rd;
    bus(1'b1, `REG_STAT, 32'h0000_0006);
  endtask
  task automatic t_reset();
    bus(1'b0, `REG_CTRL, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, `REG_STAT, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 3'h7, 32'hFFFF_FFFF);
    bus(1'b0, 3'h7, 32'h0);
    check(rd, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_endpoint();
    slow <= 1'b1;
    bus(1'b1, `REG_LOWER, 32'h0010_0004);
    send(4'h8, 32'hBEEF_0008, 32'h3C15_06A7, 32'h0002_0005, 2);
    check(desc[31:0], 32'h0010_0004);
    check(desc[45:43], CPL_SC);
    check(desc[46], 1'b1);
    check(poisoned, 1'b1);
    check(desc[63:48], 16'hBEEF);
    check(desc[71:64], 8'hA7);
    check(desc[74:72], 3'h6);
    check(desc[79:75], 5'h15);
    check(desc[87:80], 8'h3C);
    check(desc[88], 1'b1);
    check(cid, 13'h0795);
    check(desc[91:89], 3'h5);
    check({pkts - p0, pays - q0, pay_last, stat[`STAT_DONE]}, {8'h1, 8'h2, 32'hC0DE_0001, 1'b1});
    send(4'h0, 32'hBEEF_0000, 32'h3C15_06A7, 32'h0000_0005, 0);
    check({desc[88:75], poisoned}, 15'h0);
    check(cid, 13'h0A5);
    slow <= 1'b0;
    $display("test endpoint done");
  endtask
  task automatic t_errors();
    logic [2:0] st;
    for (int i = 0; i < 2; i++)
    begin
      st = (i == 0) ? CPL_UR : CPL_CA;
      send(4'h0, {16'h1234, 13'h0, st}, 32'h0000_0001, 32'h0003_0000, 3);
      check(desc[45:43], st);
      check({desc[42:32], pays - q0, pkts - p0}, {11'h0, 8'h0, 8'h1});
    end
    send(4'h0, 32'h1234_0002, 32'h0000_0001, 32'h0, 0);
    check({pkts - p0, stat[`STAT_ERR], stat[`STAT_DONE]}, {8'h0, 1'b1, 1'b0});
    bus(1'b0, `REG_STAT, 32'h0);
    check(rd[`STAT_ERR], 1'b0);
    $display("test errors done");
  endtask
  task automatic t_rc();
    rc <= 1'b1;
    send(4'h2, 32'h0000_0000, 32'h3C15_06A7, 32'h0, 0);
    check(desc[87:80], 8'h3C);
    check(desc[79:72], 8'hAE);
    check({desc[88], cid}, {1'b0, 13'h0795});
    send(4'h6, 32'h0000_0000, 32'h3C15_D6A7, 32'h0, 0);
    check(desc[79:72], 8'hD6);
    bus(1'b0, `REG_CTRL, 32'h0);
    check(rd, 32'h0000_0006);
    rc <= 1'b0;
    $display("test root complex done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    errors++;
    test_done();
  end
  initial
  begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_endpoint();
    t_errors();
    t_rc();
    test_done();
  end
endmodule
`default_nettype wire

/* cpl_framer.sv */
// Completion framer: software fills descriptor fields and a payload store
// over Avalon-MM, then the block sends one stream packet per completion.
// Assumes the core's stream sink shares clk_sys; tready is same-domain logic.
//
// How it works
// R1: Status only success, unsupported or abort.
// R2: Poison bit set only on software request.
// R3: Core marks poisoned completions; not ours.
// R4: Requester ID copied into bits 63:48.
// R5: Tag copied into bits 71:64.
// R6: Function number placed in bits 79:72.
// R7: ARI uses eight function bits, else three.
// R8: Root complex without ARI supplies device number.
// R9: Endpoint supplied device number sets override.
// R10: Root complex always supplies bus number.
// R11: Endpoint supplied bus number sets override.
// R12: Core picks captured or supplied IDs.
// R13: Core honours override only as endpoint.
// R14: Traffic class copied into bits 91:89.
// R15: One packet per completion, descriptor first.
// R16: Unsupported or abort carries zero dwords.
// R17: Core rejects illegal status encodings.
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cpl_regs.svh"

module cpl_framer
  import cpl_types_pkg::*;
#(
  parameter int PAY_DEPTH = 16
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [31:0] cc_tdata,
  output logic cc_tvalid,
  output logic cc_tlast,
  input wire logic cc_tready
);
  localparam int PAW = $clog2(PAY_DEPTH);

  function automatic logic legal_status(input logic [2:0] s);
    legal_status = (s == CPL_SC) || (s == CPL_UR) || (s == CPL_CA);
  endfunction

  // Avalon slave: one wait cycle, answer registered
  logic wait_q;
  logic [31:0] rdata_q;
  logic [2:0] ctrl_q;
  logic [31:0] cpl_a_q;
  logic [31:0] cpl_b_q;
  logic [31:0] cpl_c_q;
  logic [31:0] lower_q;
  logic err_q;
  logic done_q;
  logic [31:0] pay_mem [PAY_DEPTH];
  logic [PAW:0] wr_ptr_q;
  frame_state_t state_q;
  logic [95:0] desc_q;
  logic [10:0] beat_q;
  logic head_valid_q;
  logic [31:0] head_data_q;
  logic head_last_q;
  logic tail_valid_q;
  logic [31:0] tail_data_q;
  logic tail_last_q;

  wire wr_acc = avs_write && !wait_q;
  wire go_fire = wr_acc && (avs_address == `REG_CTRL) && avs_writedata[`CTRL_GO];
  wire busy = (state_q != ST_IDLE) || head_valid_q;
  wire start = go_fire && !busy;

  wire [31:0] stat_word = {29'h0, done_q, err_q, busy};
  wire [31:0] rd_mux =
    (avs_address == `REG_CTRL) ? {28'h0, ctrl_q, 1'b0} :
    (avs_address == `REG_STAT) ? stat_word :
    (avs_address == `REG_CPL_A) ? cpl_a_q :
    (avs_address == `REG_CPL_B) ? cpl_b_q :
    (avs_address == `REG_CPL_C) ? cpl_c_q :
    (avs_address == `REG_LOWER) ? lower_q :
    (avs_address == `REG_PAYLOAD) ? {{(31 - PAW){1'b0}}, wr_ptr_q} : 32'h0000_0000;

  // Descriptor assembly from the software fields
  wire [2:0] f_status = cpl_a_q[`A_STATUS_LO +: 3];
  wire f_poison = cpl_a_q[`A_POISON];
  wire [15:0] f_reqid = cpl_a_q[`A_REQID_LO +: 16];
  wire [7:0] f_tag = cpl_b_q[`B_TAG_LO +: 8];
  wire [7:0] f_fn = cpl_b_q[`B_FN_LO +: 8];
  wire [4:0] f_dev = cpl_b_q[`B_DEV_LO +: 5];
  wire [7:0] f_bus = cpl_b_q[`B_BUS_LO +: 8];
  wire [2:0] f_tc = cpl_c_q[`C_TC_LO +: 3];
  wire rc = ctrl_q[`CTRL_RC - 1];
  wire ari = ctrl_q[`CTRL_ARI - 1];
  wire supply = ctrl_q[`CTRL_SUPPLY - 1];
  wire give_ids = rc || supply;
  wire ovr = !rc && supply;
  wire [7:0] fn_field = ari ? f_fn : {(give_ids ? f_dev : 5'h00), f_fn[2:0]};
  wire [10:0] dw_field = (f_status == CPL_SC) ? cpl_c_q[`C_DWCNT_LO +: 11] : 11'h000;
  wire [95:0] desc_build = {
    4'h0, f_tc, ovr, (give_ids ? f_bus : 8'h00), fn_field, f_tag, f_reqid, // R4 R5 R6 R7 R8 R9 R10 R11 R14
    1'b0, f_poison, f_status, dw_field, lower_q}; // R1 R2 R16

  // Frame source feeding the two-entry buffer
  wire [10:0] dw_q = desc_q[`DESC_DWCNT_LO +: 11];
  wire in_ready = !tail_valid_q;
  wire push = (state_q != ST_IDLE) && in_ready;
  wire desc_end = (state_q == ST_DESC) && (beat_q[1:0] == `DESC_LAST_BEAT);
  wire pay_end = (state_q == ST_PAY) && (beat_q == dw_q - 11'h001);
  wire in_last = (desc_end && (dw_q == 11'h000)) || pay_end;
  wire [31:0] desc_word = (beat_q[1:0] == 2'h0) ? desc_q[31:0] :
    (beat_q[1:0] == 2'h1) ? desc_q[63:32] : desc_q[95:64];
  wire [31:0] in_data = (state_q == ST_PAY) ? pay_mem[beat_q[PAW-1:0]] : desc_word;
  wire pop = head_valid_q && cc_tready;
  wire head_take = !head_valid_q || pop;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      wait_q <= !((avs_read || avs_write) && wait_q);
      if (avs_read && wait_q)
        rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ctrl_q <= `CTRL_RESET;
      cpl_a_q <= `CPL_RESET;
      cpl_b_q <= `CPL_RESET;
      cpl_c_q <= `CPL_RESET;
      lower_q <= `CPL_RESET;
    end
    else if (wr_acc && !busy)
    begin
      // Fields are frozen while a packet is on its way
      if (avs_address == `REG_CTRL)
        ctrl_q <= avs_writedata[`CTRL_SUPPLY:`CTRL_RC];
      if (avs_address == `REG_CPL_A)
        cpl_a_q <= avs_writedata;
      if (avs_address == `REG_CPL_B)
        cpl_b_q <= avs_writedata;
      if (avs_address == `REG_CPL_C)
        cpl_c_q <= avs_writedata;
      if (avs_address == `REG_LOWER)
        lower_q <= avs_writedata;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (wr_acc && !busy && (avs_address == `REG_PAYLOAD) && (wr_ptr_q < PAY_DEPTH[PAW:0]))
      pay_mem[wr_ptr_q[PAW-1:0]] <= avs_writedata;
  end

  // Sticky flags: a hardware set in the clearing cycle wins
  wire clr_err = wr_acc && (avs_address == `REG_STAT) && avs_writedata[`STAT_ERR];
  wire clr_done = wr_acc && (avs_address == `REG_STAT) && avs_writedata[`STAT_DONE];
  wire bad_go = start && !legal_status(f_status);
  wire frame_done = push && in_last;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      err_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      err_q <= bad_go || (err_q && !clr_err); // R1 R17
      done_q <= frame_done || (done_q && !clr_done);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      wr_ptr_q <= '0;
    else if (frame_done || bad_go)
      wr_ptr_q <= '0;
    else if (wr_acc && !busy && (avs_address == `REG_PAYLOAD) && (wr_ptr_q < PAY_DEPTH[PAW:0]))
      wr_ptr_q <= wr_ptr_q + 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_q <= ST_IDLE;
      desc_q <= 96'h0;
      beat_q <= 11'h000;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (start && legal_status(f_status)) // R1 R17
          begin
            desc_q <= desc_build;
            beat_q <= 11'h000;
            state_q <= ST_DESC;
          end
        end
        ST_DESC:
        begin
          if (push)
          begin
            // One packet per completion, descriptor beats first
            if (desc_end) // R15
            begin
              beat_q <= 11'h000;
              state_q <= (dw_q == 11'h000) ? ST_IDLE : ST_PAY; // R16
            end
            else
              beat_q <= beat_q + 11'h001;
          end
        end
        ST_PAY:
        begin
          if (push)
          begin
            beat_q <= beat_q + 11'h001;
            if (pay_end)
              state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Two-entry buffer; the tail absorbs one beat when the core stalls
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      head_valid_q <= 1'b0;
      head_data_q <= 32'h0000_0000;
      head_last_q <= 1'b0;
      tail_valid_q <= 1'b0;
      tail_data_q <= 32'h0000_0000;
      tail_last_q <= 1'b0;
    end
    else if (head_take)
    begin
      if (tail_valid_q)
      begin
        head_valid_q <= 1'b1;
        head_data_q <= tail_data_q;
        head_last_q <= tail_last_q;
        tail_valid_q <= 1'b0;
      end
      else
      begin
        head_valid_q <= push;
        head_data_q <= in_data;
        head_last_q <= in_last;
      end
    end
    else if (push)
    begin
      tail_valid_q <= 1'b1;
      tail_data_q <= in_data;
      tail_last_q <= in_last;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign cc_tdata = head_data_q;
  assign cc_tvalid = head_valid_q;
  assign cc_tlast = head_last_q;

  // Beat index on the stream, for the checks below
  logic [10:0] out_beat_q;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      out_beat_q <= 11'h000;
    else if (pop)
      out_beat_q <= head_last_q ? 11'h000 : out_beat_q + 11'h001;
  end
  wire at_w1 = cc_tvalid && (out_beat_q == 11'h001);
  wire at_w2 = cc_tvalid && (out_beat_q == 11'h002);

  property p_status_legal;
    @(posedge clk_sys) disable iff (reset)
    at_w1 |-> legal_status(cc_tdata[13:11]);
  endproperty
  a_status_legal: assert property (p_status_legal) else $error("illegal completion status sent"); // R1

  property p_poison_src;
    @(posedge clk_sys) disable iff (reset)
    start ##1 (state_q == ST_DESC) |-> desc_q[`DESC_POISON] == $past(f_poison);
  endproperty
  a_poison_src: assert property (p_poison_src) else $error("poison bit not from software"); // R2

  property p_reqid;
    @(posedge clk_sys) disable iff (reset)
    at_w1 |-> cc_tdata[31:16] == desc_q[`DESC_REQID_LO +: 16];
  endproperty
  a_reqid: assert property (p_reqid) else $error("requester id misplaced"); // R4

  property p_tag_tc;
    @(posedge clk_sys) disable iff (reset)
    at_w2 |-> (cc_tdata[7:0] == desc_q[`DESC_TAG_LO +: 8]) && (cc_tdata[27:25] == desc_q[`DESC_TC_LO +: 3]);
  endproperty
  a_tag_tc: assert property (p_tag_tc) else $error("tag or traffic class misplaced"); // R5

  property p_fn_field;
    @(posedge clk_sys) disable iff (reset)
    start && legal_status(f_status) |=>
      desc_q[`DESC_FN_LO +: 3] == $past(f_fn[2:0]) &&
      (!$past(ari) || desc_q[`DESC_FN_LO +: 8] == $past(f_fn));
  endproperty
  a_fn_field: assert property (p_fn_field) else $error("function field wrong"); // R7

  property p_rc_ids;
    @(posedge clk_sys) disable iff (reset)
    start && legal_status(f_status) && rc |=>
      desc_q[`DESC_BUS_LO +: 8] == $past(f_bus) && !desc_q[`DESC_OVR] &&
      ($past(ari) || desc_q[`DESC_DEV_LO +: 5] == $past(f_dev));
  endproperty
  a_rc_ids: assert property (p_rc_ids) else $error("root complex ids missing"); // R10

  property p_ep_override;
    @(posedge clk_sys) disable iff (reset)
    start && legal_status(f_status) && !rc |=> desc_q[`DESC_OVR] == $past(supply) &&
      ($past(supply) || desc_q[`DESC_BUS_LO +: 8] == 8'h00);
  endproperty
  a_ep_override: assert property (p_ep_override) else $error("endpoint override inconsistent"); // R11

  property p_err_zero;
    @(posedge clk_sys) disable iff (reset)
    at_w1 && (cc_tdata[13:11] != CPL_SC) |-> cc_tdata[10:0] == 11'h000 && !cc_tlast ##1
      (!cc_tvalid || out_beat_q != 11'h002 || cc_tlast);
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error completion carries data"); // R16

  sequence s_stalled;
    cc_tvalid && !cc_tready;
  endsequence
  property p_hold;
    @(posedge clk_sys) disable iff (reset)
    s_stalled |=> cc_tvalid && $stable(cc_tdata) && $stable(cc_tlast);
  endproperty
  a_hold: assert property (p_hold) else $error("stream changed while stalled"); // R15

  property p_no_gap;
    @(posedge clk_sys) disable iff (reset)
    cc_tvalid && cc_tready && !cc_tlast |=> cc_tvalid;
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("valid dropped inside packet"); // R15
endmodule
`default_nettype wire

/* cpl_regs.svh */
// Register map, field positions, reset values and descriptor layout
// for the completion framer; included by the framer module and its bench.
`ifndef CPL_REGS_SVH
`define CPL_REGS_SVH

// Word indices on the Avalon-MM slave (byte address = 4 * index)
`define REG_CTRL 3'h0
`define REG_STAT 3'h1
`define REG_CPL_A 3'h2
`define REG_CPL_B 3'h3
`define REG_CPL_C 3'h4
`define REG_LOWER 3'h5
`define REG_PAYLOAD 3'h6

// Control and status bit positions
`define CTRL_GO 0
`define CTRL_RC 1
`define CTRL_ARI 2
`define CTRL_SUPPLY 3
`define STAT_BUSY 0
`define STAT_ERR 1
`define STAT_DONE 2

// Field positions inside the software registers
`define A_STATUS_LO 0
`define A_POISON 3
`define A_REQID_LO 16
`define B_TAG_LO 0
`define B_FN_LO 8
`define B_DEV_LO 16
`define B_BUS_LO 24
`define C_TC_LO 0
`define C_DWCNT_LO 16

// Reset values
`define CTRL_RESET 3'h0
`define CPL_RESET 32'h0000_0000

// Descriptor layout (96 bits, sent as three 32-bit beats, low word first)
`define DESC_DWCNT_LO 32
`define DESC_STATUS_LO 43
`define DESC_POISON 46
`define DESC_REQID_LO 48
`define DESC_TAG_LO 64
`define DESC_FN_LO 72
`define DESC_DEV_LO 75
`define DESC_BUS_LO 80
`define DESC_OVR 88
`define DESC_TC_LO 89
`define DESC_LAST_BEAT 2'h2

`endif

/* cpl_types_pkg.sv */
// Types shared by the completion framer.
// Assumes nothing of its surroundings.
`default_nettype none
package cpl_types_pkg;
  typedef enum logic [2:0] {CPL_SC = 3'h0, CPL_UR = 3'h1, CPL_CA = 3'h4} cpl_status_t;
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_DESC = 2'h1, ST_PAY = 2'h3} frame_state_t;
endpackage
`default_nettype wire
